/* rtl/host_status_interrupt_regs.sv */
module host_status_interrupt_regs #(
  parameter int INIT_CYCLES = 75_000_000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] bus_addr,
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  input  wire logic       iack,
  input  wire logic       iack_in,
  output logic            iack_out,
  output logic            irq_req,
  output logic            vector_valid,
  input  wire logic       tx_space,
  input  wire logic       rx_avail,
  input  wire logic       completion_pulse,
  input  wire logic       overtravel_pulse,
  input  wire logic       slip_pulse,
  input  wire logic       slip_irq_command,
  input  wire logic       encoder_fitted,
  input  wire logic       cmd_err_pulse,
  input  wire logic [3:0] axis_done_set,
  input  wire logic       init_busy,
  output logic            data_wr_pulse,
  output logic            data_rd_pulse
);

  // ****************************************
  // Access decode
  // ****************************************
  wire logic rd_data   = bus_rd && (bus_addr == host_status_pkg::OFS_DATA);
  wire logic wr_data   = bus_wr && (bus_addr == host_status_pkg::OFS_DATA);
  wire logic rd_done   = bus_rd && (bus_addr == host_status_pkg::OFS_DONE);
  wire logic rd_status = bus_rd && (bus_addr == host_status_pkg::OFS_STATUS);
  wire logic wr_ctrl   = bus_wr && (bus_addr == host_status_pkg::OFS_CTRL);
  wire logic wr_vector = bus_wr && (bus_addr == host_status_pkg::OFS_VECTOR);

  logic [7:0] ctrl_r;
  logic [7:0] irq_vector_value_r;
  logic       tx_empty_flag_r;
  logic       rx_full_flag_r;
  logic       done_or_error_flag_r;
  logic       overtravel_flag_r;
  logic       slip_flag_r;
  logic       cmd_err_flag_r;
  logic       init_flag_r;
  logic [3:0] axis_done_r;
  logic       tx_space_d_r;
  logic       rx_avail_d_r;

  // ****************************************
  // Event detection
  // ****************************************
  // Edge-triggered so a flag cleared by an access stays clear until
  // the buffer condition recurs
  wire logic tx_rise  = tx_space && !tx_space_d_r;
  wire logic rx_rise  = rx_avail && !rx_avail_d_r;
  wire logic slip_set = slip_pulse && slip_irq_command
                        && encoder_fitted;
  wire logic err_any  = overtravel_pulse || slip_set || cmd_err_pulse;
  wire logic done_set = completion_pulse || err_any;

  // ****************************************
  // Status and interrupt
  // ****************************************
  wire logic [3:0] err_bits = {overtravel_flag_r, slip_flag_r,
                               init_flag_r, cmd_err_flag_r};
  wire logic irq_s = done_or_error_flag_r || rx_full_flag_r
                     || tx_empty_flag_r;
  // Status ignores enables so polling sees every source
  wire logic [7:0] host_status_flags = {irq_s, tx_empty_flag_r,
                                        rx_full_flag_r,
                                        done_or_error_flag_r,
                                        err_bits};
  wire logic [7:0] ctrl_rd = {ctrl_r[7:4], 4'h0};
  localparam int BIT_D = host_status_pkg::BIT_DONE;
  localparam int BIT_R = host_status_pkg::BIT_RX_FULL;
  localparam int BIT_T = host_status_pkg::BIT_TX_EMPTY;
  localparam int BIT_M = host_status_pkg::BIT_IRQ;
  wire logic src_en = (done_or_error_flag_r && ctrl_r[BIT_D])
                      || (rx_full_flag_r && ctrl_r[BIT_R])
                      || (tx_empty_flag_r && ctrl_r[BIT_T]);

  assign irq_req = ctrl_r[BIT_M] && src_en;
  // Only the board that is requesting and holds the daisy chain answers
  wire logic ack_mine = iack && iack_in && irq_req;
  assign vector_valid  = ack_mine;
  assign iack_out      = iack && iack_in && !irq_req;
  assign data_wr_pulse = wr_data;
  assign data_rd_pulse = rd_data;

  // ****************************************
  // Read mux
  // ****************************************
  wire logic [7:0] rd_mux =
    ack_mine ? irq_vector_value_r :
    (bus_addr == host_status_pkg::OFS_DONE) ?
      {4'h0, axis_done_r} :
    (bus_addr == host_status_pkg::OFS_CTRL)   ? ctrl_rd :
    (bus_addr == host_status_pkg::OFS_STATUS) ? host_status_flags :
    (bus_addr == host_status_pkg::OFS_VECTOR) ? irq_vector_value_r :
    host_status_pkg::BYTE_ZERO;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_rdata <= host_status_pkg::BYTE_ZERO;
    else if (bus_rd || ack_mine)
      bus_rdata <= rd_mux;
  end

  // ****************************************
  // Control and vector registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r             <= host_status_pkg::RST_CTRL;
      irq_vector_value_r <= host_status_pkg::RST_VECTOR;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= {bus_wdata[7:4], 4'h0};
      if (wr_vector)
        irq_vector_value_r <= bus_wdata;
    end
  end

  // ****************************************
  // Sticky flags: set wins over clear
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_empty_flag_r      <= 1'b0;
      rx_full_flag_r       <= 1'b0;
      done_or_error_flag_r <= 1'b0;
      overtravel_flag_r    <= 1'b0;
      slip_flag_r          <= 1'b0;
      cmd_err_flag_r       <= 1'b0;
      axis_done_r          <= host_status_pkg::RST_AXIS;
      tx_space_d_r         <= 1'b0;
      rx_avail_d_r         <= 1'b0;
    end
    else
    begin
      tx_space_d_r <= tx_space;
      rx_avail_d_r <= rx_avail;
      if (tx_rise)
        tx_empty_flag_r <= 1'b1;
      else if (wr_data)
        tx_empty_flag_r <= 1'b0;
      if (rx_rise)
        rx_full_flag_r <= 1'b1;
      else if (rd_data)
        rx_full_flag_r <= 1'b0;
      if (done_set)
        done_or_error_flag_r <= 1'b1;
      else if (rd_status)
        done_or_error_flag_r <= 1'b0;
      if (overtravel_pulse)
        overtravel_flag_r <= 1'b1;
      else if (rd_status)
        overtravel_flag_r <= 1'b0;
      if (slip_set)
        slip_flag_r <= 1'b1;
      else if (rd_status)
        slip_flag_r <= 1'b0;
      if (cmd_err_pulse)
        cmd_err_flag_r <= 1'b1;
      else if (rd_status)
        cmd_err_flag_r <= 1'b0;
      axis_done_r <= (rd_done ? host_status_pkg::RST_AXIS : axis_done_r)
                     | axis_done_set;
    end
  end

  // ****************************************
  // Init flag: high from reset until init ends, never again
  // ****************************************
  // Once low it latches low, so a glitch on init_busy cannot reraise it
  logic init_done_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      init_flag_r <= 1'b1;
      init_done_r <= 1'b0;
    end
    else if (!init_done_r && !init_busy)
    begin
      init_flag_r <= 1'b0;
      init_done_r <= 1'b1;
    end
  end

  wire logic unused_ok = |{INIT_CYCLES, host_status_pkg::ERR_NONE};

endmodule : host_status_interrupt_regs

/* rtl/host_status_pkg.sv */
package host_status_pkg;

  // ****************************************
  // Register offsets (odd bytes only)
  // ****************************************
  localparam logic [3:0] OFS_DATA    = 4'h1;
  localparam logic [3:0] OFS_DONE    = 4'h3;
  localparam logic [3:0] OFS_CTRL    = 4'h5;
  localparam logic [3:0] OFS_STATUS  = 4'h7;
  localparam logic [3:0] OFS_VECTOR  = 4'h9;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CMD_ERR   = 0;
  localparam int BIT_INIT      = 1;
  localparam int BIT_SLIP      = 2;
  localparam int BIT_OVRTRAVEL = 3;
  localparam int BIT_DONE      = 4;
  localparam int BIT_RX_FULL   = 5;
  localparam int BIT_TX_EMPTY  = 6;
  localparam int BIT_IRQ       = 7;

  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_VECTOR  = 8'h0f;
  localparam logic [3:0] RST_AXIS    = 4'h0;
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int INIT_SETTLE_MS  = 1500;
  localparam longint INIT_SETTLE_CYC =
    longint'(CLK_HZ) * INIT_SETTLE_MS / 1000;

endpackage : host_status_pkg

/* tb/host_bus_model.sv */
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_rdata,
  output logic      [3:0] bus_addr,
  output logic            bus_rd,
  output logic            bus_wr,
  output logic      [7:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bus_addr = 4'h0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // Released data shows the inverse, never a stale copy
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~v;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd
endmodule : host_bus_model

/* tb/host_status_checker.sv */
module host_status_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] bus_addr,
  input wire logic       bus_rd,
  input wire logic       bus_wr,
  input wire logic [7:0] bus_rdata,
  input wire logic       iack,
  input wire logic       iack_in,
  input wire logic       iack_out,
  input wire logic       irq_req,
  input wire logic       vector_valid,
  input wire logic       init_busy,
  input wire logic       data_wr_pulse,
  input wire logic       data_rd_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd_s = bus_rd && bus_addr == 4'h7;
  a_irq_summary:
    assert property (rd_s |=> bus_rdata[7] == |bus_rdata[6:4])
    else $error("summary bit mismatch");
  a_init_high:
    assert property (rd_s && init_busy && $past(init_busy) |=> bus_rdata[1])
    else $error("init flag low while busy");
  a_init_low:
    assert property (rd_s && !init_busy && !$past(init_busy) |=> !bus_rdata[1])
    else $error("init flag high after init");
  a_done_upper:
    assert property (bus_rd && bus_addr == 4'h3 |=> bus_rdata[7:4] == 4'h0)
    else $error("axis done upper bits set");
  a_ctrl_lower:
    assert property (bus_rd && bus_addr == 4'h5 |=> bus_rdata[3:0] == 4'h0)
    else $error("control low bits set");
  a_unmapped_zero:
    assert property (bus_rd && bus_addr == 4'hb |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ack_pass:
    assert property (iack_out == (iack && iack_in && !irq_req))
    else $error("ack chain wrong");
  a_vector_gate:
    assert property (vector_valid |-> iack && iack_in && irq_req)
    else $error("vector without grant");
  a_data_write:
    assert property (data_wr_pulse == (bus_wr && bus_addr == 4'h1))
    else $error("data write strobe wrong");
  a_data_read:
    assert property (data_rd_pulse == (bus_rd && bus_addr == 4'h1))
    else $error("data read strobe wrong");
endmodule : host_status_checker
bind host_status_interrupt_regs host_status_checker u_chk (.clk, .rst,
  .bus_addr, .bus_rd, .bus_wr, .bus_rdata, .iack, .iack_in, .iack_out,
  .irq_req, .vector_valid, .init_busy, .data_wr_pulse, .data_rd_pulse);

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst = 1'b1, iack = 1'b0, iack_in = 1'b0;
  logic       tx_space = 1'b0, rx_avail = 1'b0, slip_on = 1'b0;
  logic       init_busy = 1'b1, bus_rd, bus_wr, iack_out, irq_req, vvalid;
  logic [3:0] ev_r = 4'h0, axis_r = 4'h0, bus_addr;
  logic [7:0] bus_wdata, bus_rdata, d;
  int         bad_count = 0, checked = 0;
  logic [3:0] evs [4] = '{4'h8, 4'h2, 4'h4, 4'h4};
  logic [7:0] exps [4] = '{8'h91, 8'h98, 8'h00, 8'h94};
  always #10 clk = ~clk;
  host_status_interrupt_regs #(.INIT_CYCLES(16)) u_dut (.clk, .rst,
    .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .iack, .iack_in,
    .iack_out, .irq_req, .vector_valid(vvalid), .tx_space, .rx_avail,
    .completion_pulse(ev_r[0]), .overtravel_pulse(ev_r[1]),
    .slip_pulse(ev_r[2]), .cmd_err_pulse(ev_r[3]), .slip_irq_command(slip_on),
    .encoder_fitted(slip_on), .axis_done_set(axis_r), .init_busy,
    .data_wr_pulse(), .data_rd_pulse());
  host_bus_model u_host (.clk, .bus_rdata, .bus_addr, .bus_rd, .bus_wr,
    .bus_wdata);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task rc(input logic [3:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rc
  task fire(input logic [3:0] v, input logic [3:0] ax);
    @(posedge clk);
    ev_r <= v;
    axis_r <= ax;
    @(posedge clk);
    ev_r <= 4'h0;
    axis_r <= 4'h0;
  endtask : fire
  task close_out;
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(4'h5, 8'h00);
    rc(4'h9, 8'h0f);
    rc(4'h7, 8'h02);
    @(posedge clk);
    init_busy <= 1'b0;
    rc(4'h7, 8'h00);
    u_host.wr(4'h9, 8'ha5);
    rc(4'h9, 8'ha5);
    u_host.wr(4'h5, 8'hf0);
    rc(4'h5, 8'hf0);
    u_host.wr(4'h7, 8'hff);
    rc(4'h7, 8'h00);
    rc(4'hb, 8'h00);
    $display("test registers done");
    @(posedge clk);
    tx_space <= 1'b1;
    repeat (3) @(posedge clk);
    rc(4'h7, 8'hc0);
    chk({7'h0, irq_req}, 8'h01);
    @(posedge clk);
    iack <= 1'b1;
    iack_in <= 1'b1;
    #1 chk({6'h0, vvalid, iack_out}, 8'h02);
    @(posedge clk);
    iack <= 1'b0;
    iack_in <= 1'b0;
    #1 chk(bus_rdata, 8'ha5);
    u_host.wr(4'h1, 8'h41);
    rc(4'h7, 8'h00);
    chk({7'h0, irq_req}, 8'h00);
    @(posedge clk);
    rx_avail <= 1'b1;
    repeat (3) @(posedge clk);
    u_host.wr(4'h5, 8'h70);
    rc(4'h7, 8'ha0);
    chk({7'h0, irq_req}, 8'h00);
    u_host.rd(4'h1, d);
    rc(4'h7, 8'h00);
    $display("test buffers done");
    fire(4'h1, 4'h5);
    rc(4'h7, 8'h90);
    rc(4'h3, 8'h05);
    rc(4'h7, 8'h00);
    rc(4'h3, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      slip_on <= (i == 3);
      fire(evs[i], 4'h0);
      rc(4'h7, exps[i]);
      rc(4'h7, 8'h00);
    end
    $display("test events done");
    close_out;
  end
endmodule : tb
